/* design/alrw_entry_write.sv */
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "alrw_defs.svh"

// Summary of operation
// - Low word holds first 32 MAC bits
// - High word 15:0 holds last 16 MAC bits
// - Valid commits entry; clear invalidates matching entry
// - Static plus override forwards despite port state
// - Static entries untouched by aging and learning
// - Non-static idle entries removed after 5-10 minutes
// - Filter bit discards matching destination packets
// - Priority used only if static and global enable
// - Bit 18 clear selects one port, except port field 3, which selects none
// - Bit 18 set selects a port group
// - Make entry writes staged words into table
module alrw_entry_write
	import alrw_pkg::*;
#(
	parameter logic [63:0] AGE_CYCLES = `ALRW_AGE_CYCLES
) (
	// Clock and reset
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	// Avalon-MM slave
	input wire logic [15:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	// Source address learning
	input wire logic I_LRN_VALID,
	input wire logic [47:0] I_LRN_SA,
	input wire logic [1:0] I_LRN_PORT,
	// Destination address lookup
	input wire logic I_LKP_VALID,
	input wire logic [47:0] I_LKP_DA,
	input wire logic [1:0] I_LKP_INGRESS,
	input wire logic [2:0] I_LKP_PORT_FWD,
	output logic O_LKP_DONE,
	output logic O_LKP_HIT,
	output logic [2:0] O_LKP_MASK,
	output logic O_LKP_DROP,
	output logic O_LKP_PRIO_EN,
	output logic [1:0] O_LKP_PRIO
);

	localparam int N = `ALRW_ENTRIES;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Port field to port mask
	function automatic logic [2:0] port_mask(input logic [2:0] field);
		logic [2:0] m;
		m = 3'h0;
		unique case (field)
			3'h0: m = 3'h1;
			3'h1: m = 3'h2;
			3'h2: m = 3'h4;
			3'h3: m = 3'h0;
			3'h4: m = 3'h3;
			3'h5: m = 3'h5;
			3'h6: m = 3'h6;
			3'h7: m = 3'h7;
		endcase
		return m;
	endfunction

	function automatic logic [N-1:0] match_vec(input alrw_entry_t t [N], input logic [47:0] mac);
		logic [N-1:0] v;
		v = '0;
		for (int k = 0; k < N; k++) begin
			v[k] = t[k].valid && (t[k].mac == mac);
		end
		return v;
	endfunction

	function automatic logic [N-1:0] first_set(input logic [N-1:0] v);
		logic [N-1:0] r;
		logic found;
		r = '0;
		found = 1'b0;
		for (int k = 0; k < N; k++) begin
			if (v[k] && !found) begin
				r[k] = 1'b1;
				found = 1'b1;
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register bus

	logic [31:0] wr_low_ff, nxt_wr_low;
	logic [31:0] wr_high_ff, nxt_wr_high;
	logic [31:0] cmd_ff, nxt_cmd;
	logic [31:0] ing_cfg_ff, nxt_ing_cfg;
	logic [31:0] rdata_ff, nxt_rdata;
	logic wait_ff, nxt_wait;
	logic make_pend_ff;
	logic [13:0] reg_idx;
	logic bus_wr;

	assign reg_idx = I_AVS_ADDRESS[15:2];
	assign bus_wr = I_AVS_WRITE && !wait_ff;

	always_comb begin
		nxt_wait = !((I_AVS_READ || I_AVS_WRITE) && wait_ff);
		nxt_rdata = rdata_ff;
		nxt_wr_low = wr_low_ff;
		nxt_wr_high = wr_high_ff;
		nxt_cmd = cmd_ff;
		nxt_ing_cfg = ing_cfg_ff;
		if (I_AVS_READ && wait_ff) begin
			unique case (reg_idx)
				`ALRW_IDX_CMD: nxt_rdata = cmd_ff;
				`ALRW_IDX_WR_LOW: nxt_rdata = wr_low_ff;
				`ALRW_IDX_WR_HIGH: nxt_rdata = wr_high_ff & `ALRW_HI_WMASK;
				`ALRW_IDX_CMD_STS: nxt_rdata = {31'h0, make_pend_ff};
				`ALRW_IDX_INGRESS_CFG: nxt_rdata = ing_cfg_ff;
				default: nxt_rdata = 32'h0;
			endcase
		end
		if (bus_wr) begin
			unique case (reg_idx)
				`ALRW_IDX_CMD: begin
					nxt_cmd = merge_be(cmd_ff, I_AVS_WRITEDATA, I_AVS_BYTEENABLE)
						& (32'h1 << `ALRW_CMD_MAKE);
				end
				`ALRW_IDX_WR_LOW: begin
					nxt_wr_low = merge_be(wr_low_ff, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
				end
				`ALRW_IDX_WR_HIGH: begin
					nxt_wr_high = merge_be(wr_high_ff, I_AVS_WRITEDATA, I_AVS_BYTEENABLE)
						& `ALRW_HI_WMASK;
				end
				`ALRW_IDX_INGRESS_CFG: begin
					nxt_ing_cfg = merge_be(ing_cfg_ff, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0;
			wr_low_ff <= `ALRW_RST_WR_LOW;
			wr_high_ff <= `ALRW_RST_WR_HIGH;
			cmd_ff <= `ALRW_RST_CMD;
			ing_cfg_ff <= `ALRW_RST_INGRESS_CFG;
		end else begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
			wr_low_ff <= nxt_wr_low;
			wr_high_ff <= nxt_wr_high;
			cmd_ff <= nxt_cmd;
			ing_cfg_ff <= nxt_ing_cfg;
		end
	end

	assign O_AVS_WAITREQUEST = wait_ff;
	assign O_AVS_READDATA = rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// Make entry sequencer

	alrw_make_state_t mk_state_ff, nxt_mk_state;
	logic nxt_make_pend;
	logic commit;

	always_comb begin
		nxt_mk_state = mk_state_ff;
		nxt_make_pend = make_pend_ff;
		commit = 1'b0;
		unique case (mk_state_ff)
			MK_IDLE: begin
				if (cmd_ff[`ALRW_CMD_MAKE]) begin
					nxt_mk_state = MK_COMMIT;
					nxt_make_pend = 1'b1;
				end
			end
			MK_COMMIT: begin
				commit = 1'b1;
				nxt_make_pend = 1'b0;
				nxt_mk_state = MK_WAIT_CLEAR;
			end
			MK_WAIT_CLEAR: begin
				if (!cmd_ff[`ALRW_CMD_MAKE]) begin
					nxt_mk_state = MK_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			mk_state_ff <= MK_IDLE;
			make_pend_ff <= 1'b0;
		end else begin
			mk_state_ff <= nxt_mk_state;
			make_pend_ff <= nxt_make_pend;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address table, learning and aging

	alrw_entry_t tbl_ff [N];
	alrw_entry_t nxt_tbl [N];
	alrw_entry_t staged;
	alrw_entry_t learned;
	logic age_tick;
	logic [N-1:0] mk_hit, mk_free, mk_sel;
	logic [N-1:0] ln_hit, ln_free;

	alrw_age_tick #(
		.CYCLES(AGE_CYCLES)
	) u_age_tick (
		.i_mclk(I_MCLK),
		.i_sys_rst(I_SYS_RST),
		.o_tick(age_tick)
	);

	always_comb begin
		staged.valid = wr_high_ff[`ALRW_HI_VALID];
		staged.age = wr_high_ff[`ALRW_HI_AGE];
		staged.stat = wr_high_ff[`ALRW_HI_STATIC];
		staged.filter = wr_high_ff[`ALRW_HI_FILTER];
		staged.prio = wr_high_ff[`ALRW_HI_PRIO_MSB:`ALRW_HI_PRIO_LSB];
		staged.port = wr_high_ff[`ALRW_HI_PORT_MSB:`ALRW_HI_PORT_LSB];
		staged.mac = {wr_high_ff[`ALRW_HI_MAC_MSB:0], wr_low_ff};
		learned = '0;
		learned.valid = 1'b1;
		learned.age = 1'b1;
		learned.port = {1'b0, I_LRN_PORT};
		learned.mac = I_LRN_SA;
		mk_hit = match_vec(tbl_ff, staged.mac);
		ln_hit = match_vec(tbl_ff, I_LRN_SA);
		for (int k = 0; k < N; k++) begin
			mk_free[k] = !tbl_ff[k].valid;
		end
		mk_sel = (mk_hit != '0) ? first_set(mk_hit) : first_set(mk_free);
		ln_free = first_set(mk_free);
		for (int k = 0; k < N; k++) begin
			nxt_tbl[k] = tbl_ff[k];
			if (age_tick && tbl_ff[k].valid && !tbl_ff[k].stat) begin
				if (tbl_ff[k].age) begin
					nxt_tbl[k].age = 1'b0;
				end else begin
					nxt_tbl[k].valid = 1'b0;
				end
			end
			if (commit) begin
				if (staged.valid && mk_sel[k]) begin
					nxt_tbl[k] = staged;
				end else if (!staged.valid && mk_hit[k]) begin
					nxt_tbl[k] = '0;
				end
			end else if (I_LRN_VALID) begin
				if (ln_hit[k] && !tbl_ff[k].stat) begin
					// A source hit in a sweep cycle keeps the entry alive
					nxt_tbl[k].valid = 1'b1;
					nxt_tbl[k].age = 1'b1;
					nxt_tbl[k].port = {1'b0, I_LRN_PORT};
				end else if (ln_hit == '0 && ln_free[k]) begin
					nxt_tbl[k] = learned;
				end
			end
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			for (int k = 0; k < N; k++) begin
				tbl_ff[k] <= '0;
			end
		end else begin
			for (int k = 0; k < N; k++) begin
				tbl_ff[k] <= nxt_tbl[k];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Destination lookup

	logic done_ff, nxt_done;
	logic hit_ff, nxt_hit;
	logic [2:0] mask_ff, nxt_mask;
	logic drop_ff, nxt_drop;
	logic prio_en_ff, nxt_prio_en;
	logic [1:0] prio_ff, nxt_prio;
	logic [N-1:0] da_hit, da_sel;
	alrw_entry_t da_ent;
	logic override;
	logic ingress_fwd;

	always_comb begin
		da_hit = match_vec(tbl_ff, I_LKP_DA);
		da_sel = first_set(da_hit);
		da_ent = '0;
		for (int k = 0; k < N; k++) begin
			if (da_sel[k]) begin
				da_ent = tbl_ff[k];
			end
		end
		override = da_ent.stat && da_ent.age;
		ingress_fwd = (I_LKP_INGRESS != 2'h3) && I_LKP_PORT_FWD[I_LKP_INGRESS];
		nxt_done = I_LKP_VALID;
		nxt_hit = 1'b0;
		nxt_mask = 3'h0;
		nxt_drop = 1'b0;
		nxt_prio_en = 1'b0;
		nxt_prio = 2'h0;
		if (I_LKP_VALID && da_hit != '0) begin
			nxt_hit = 1'b1;
			nxt_drop = da_ent.filter;
			if (!da_ent.filter) begin
				if (override) begin
					nxt_mask = port_mask(da_ent.port);
				end else if (ingress_fwd) begin
					nxt_mask = port_mask(da_ent.port) & I_LKP_PORT_FWD;
				end
			end
			nxt_prio_en = da_ent.stat && ing_cfg_ff[`ALRW_ING_DA_PRIO];
			nxt_prio = nxt_prio_en ? da_ent.prio : 2'h0;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			done_ff <= 1'b0;
			hit_ff <= 1'b0;
			mask_ff <= 3'h0;
			drop_ff <= 1'b0;
			prio_en_ff <= 1'b0;
			prio_ff <= 2'h0;
		end else begin
			done_ff <= nxt_done;
			hit_ff <= nxt_hit;
			mask_ff <= nxt_mask;
			drop_ff <= nxt_drop;
			prio_en_ff <= nxt_prio_en;
			prio_ff <= nxt_prio;
		end
	end

	assign O_LKP_DONE = done_ff;
	assign O_LKP_HIT = hit_ff;
	assign O_LKP_MASK = mask_ff;
	assign O_LKP_DROP = drop_ff;
	assign O_LKP_PRIO_EN = prio_en_ff;
	assign O_LKP_PRIO = prio_ff;

endmodule

`default_nettype wire

/* design/alrw_defs.svh */
`ifndef ALRW_DEFS_SVH
`define ALRW_DEFS_SVH

// Register indices; byte address is four times the index
`define ALRW_IDX_CMD 14'h1800
`define ALRW_IDX_WR_LOW 14'h1801
`define ALRW_IDX_WR_HIGH 14'h1802
`define ALRW_IDX_CMD_STS 14'h1808
`define ALRW_IDX_INGRESS_CFG 14'h1840

// Reset values
`define ALRW_RST_WR_LOW 32'h0000_0000
`define ALRW_RST_WR_HIGH 32'h0000_0000
`define ALRW_RST_CMD 32'h0000_0000
`define ALRW_RST_INGRESS_CFG 32'h0000_0000

// High word fields
`define ALRW_HI_WMASK 32'h01ff_ffff
`define ALRW_HI_VALID 24
`define ALRW_HI_AGE 23
`define ALRW_HI_STATIC 22
`define ALRW_HI_FILTER 21
`define ALRW_HI_PRIO_MSB 20
`define ALRW_HI_PRIO_LSB 19
`define ALRW_HI_PORT_MSB 18
`define ALRW_HI_PORT_LSB 16
`define ALRW_HI_PORT_GROUP 18
`define ALRW_HI_MAC_MSB 15

// Command, status and ingress config bits
`define ALRW_CMD_MAKE 2
`define ALRW_STS_MAKE_PEND 0
`define ALRW_ING_DA_PRIO 5

// Aging: sweep period (half of the longest life) and clock period
`define ALRW_AGE_PERIOD_S 64'd300
`define ALRW_CLK_PERIOD_NS 64'd8
`define ALRW_AGE_CYCLES ((`ALRW_AGE_PERIOD_S * 64'd1000000000) / `ALRW_CLK_PERIOD_NS)

// Table size
`define ALRW_ENTRIES 4

`endif

/* design/alrw_pkg.sv */
package alrw_pkg;

	typedef struct packed {
		logic valid;
		logic age;
		logic stat;
		logic filter;
		logic [1:0] prio;
		logic [2:0] port;
		logic [47:0] mac;
	} alrw_entry_t;

	typedef enum logic [1:0] {
		MK_IDLE,
		MK_COMMIT,
		MK_WAIT_CLEAR
	} alrw_make_state_t;

endpackage

/* design/alrw_age_tick.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alrw_defs.svh"

// Free-running aging sweep tick
module alrw_age_tick #(
	parameter logic [63:0] CYCLES = `ALRW_AGE_CYCLES
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// Tick
	output logic o_tick
);

	logic [63:0] cnt_ff;
	logic [63:0] nxt_cnt;
	logic tick_ff;
	logic nxt_tick;

	always_comb begin
		nxt_tick = 1'b0;
		nxt_cnt = cnt_ff + 64'd1;
		if (cnt_ff >= CYCLES - 64'd1) begin
			nxt_cnt = 64'd0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			cnt_ff <= 64'd0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign o_tick = tick_ff;

endmodule

`default_nettype wire

/* testbench/alrw_entry_write_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module alrw_entry_write_properties (
	// Clock and reset
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	// Register bus
	input wire logic [15:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] O_AVS_READDATA,
	input wire logic O_AVS_WAITREQUEST,
	// Lookup
	input wire logic I_LKP_VALID,
	input wire logic O_LKP_DONE,
	input wire logic O_LKP_HIT,
	input wire logic [2:0] O_LKP_MASK,
	input wire logic O_LKP_DROP,
	input wire logic O_LKP_PRIO_EN,
	input wire logic [1:0] O_LKP_PRIO
);
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_SYS_RST);
	a_wait_answer: assert property (
		(I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
		else $error("bus request not answered");
	a_wait_single: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	a_rsvd_zero: assert property (
		I_AVS_READ && !O_AVS_WAITREQUEST && I_AVS_ADDRESS[15:2] == 14'h1802
		|-> O_AVS_READDATA[31:25] == 7'h00) else $error("reserved bits nonzero");
	a_unmapped_zero: assert property (
		I_AVS_READ && !O_AVS_WAITREQUEST && !(I_AVS_ADDRESS[15:2] inside
		{14'h1800, 14'h1801, 14'h1802, 14'h1808, 14'h1840}) |-> O_AVS_READDATA == 32'h0)
		else $error("unmapped read nonzero");
	a_lkp_answer: assert property (I_LKP_VALID |=> O_LKP_DONE) else $error("lookup not answered");
	a_done_cause: assert property (O_LKP_DONE |-> $past(I_LKP_VALID)) else $error("done without lookup");
	a_idle_quiet: assert property (!O_LKP_DONE |-> !O_LKP_HIT && O_LKP_MASK == 3'h0 && !O_LKP_DROP)
		else $error("lookup outputs not idle");
	a_drop_nomask: assert property (O_LKP_DROP |-> O_LKP_HIT && O_LKP_MASK == 3'h0)
		else $error("filtered hit forwards");
	a_prio_gate: assert property (!O_LKP_PRIO_EN |-> O_LKP_PRIO == 2'h0) else $error("priority leak");
	a_prio_hit: assert property (O_LKP_PRIO_EN |-> O_LKP_HIT) else $error("priority without hit");
endmodule
bind alrw_entry_write alrw_entry_write_properties i_props (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST),
	.I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
	.O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_LKP_VALID(I_LKP_VALID),
	.O_LKP_DONE(O_LKP_DONE), .O_LKP_HIT(O_LKP_HIT), .O_LKP_MASK(O_LKP_MASK), .O_LKP_DROP(O_LKP_DROP),
	.O_LKP_PRIO_EN(O_LKP_PRIO_EN), .O_LKP_PRIO(O_LKP_PRIO));
`default_nettype wire

/* testbench/alrw_entry_write_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module alrw_entry_write_tb;
	logic mclk = 0, rst = 1, rd = 0, wr = 0, lv = 0, kv = 0;
	logic [15:0] adr = 0;
	logic [31:0] wd = 0, rdata, tmp;
	logic [3:0] be = 0;
	logic [47:0] lsa = 0, da = 0, m0, m1, m2, m3;
	logic [1:0] lp = 0, ing = 0, prio;
	logic [2:0] fwd = 0, mask;
	logic wait_o, done, hit, drop, pen;
	logic [8:0] le;
	logic [2:0] pm [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
	logic [31:0] rq [$];
	logic [8:0] lq [$];
	int err_total = 0, n_compared = 0, cyc = 0, seed = 78650;
	alrw_entry_write #(.AGE_CYCLES(64'd20)) i_alrw_entry_write (.I_MCLK(mclk), .I_SYS_RST(rst),
		.I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_o), .I_LRN_VALID(lv), .I_LRN_SA(lsa), .I_LRN_PORT(lp),
		.I_LKP_VALID(kv), .I_LKP_DA(da), .I_LKP_INGRESS(ing), .I_LKP_PORT_FWD(fwd), .O_LKP_DONE(done),
		.O_LKP_HIT(hit), .O_LKP_MASK(mask), .O_LKP_DROP(drop), .O_LKP_PRIO_EN(pen), .O_LKP_PRIO(prio));
	initial forever #4 mclk = ~mclk;
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (err_total == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic r, input logic [13:0] ix, input logic [31:0] d, input logic [3:0] b);
		@(posedge mclk);
		rd <= r;
		wr <= !r;
		adr <= {ix, 2'b00};
		wd <= d;
		be <= b;
		@(posedge mclk);
		while (wait_o !== 1'b0) @(posedge mclk);
		rd <= 0;
		wr <= 0;
	endtask
	task automatic wrr(input logic [13:0] ix, input logic [31:0] d);
		bus(0, ix, d, 4'hf);
	endtask
	task automatic rdx(input logic [13:0] ix, input logic [31:0] e);
		rq.push_back(e);
		bus(1, ix, 32'h0, 4'hf);
	endtask
	// Stage both words, pulse the make bit, then clear it
	task automatic mk(input logic [47:0] m, input logic [8:0] a);
		wrr(14'h1801, m[31:0]);
		wrr(14'h1802, {7'h00, a, m[47:32]});
		wrr(14'h1800, 32'h4);
		rdx(14'h1808, 32'h1);
		rdx(14'h1808, 32'h0);
		wrr(14'h1800, 32'h0);
	endtask
	task automatic lk(input logic [47:0] m, input logic [1:0] i, input logic [2:0] f, input logic [8:0] e);
		@(posedge mclk);
		kv <= 1;
		da <= m;
		ing <= i;
		fwd <= f;
		lq.push_back(e);
		@(posedge mclk);
		kv <= 0;
	endtask
	task automatic lrn(input logic [47:0] m, input logic [1:0] p);
		@(posedge mclk);
		lv <= 1;
		lsa <= m;
		lp <= p;
		@(posedge mclk);
		lv <= 0;
	endtask
	function automatic logic [47:0] rmac();
		logic [31:0] x;
		logic [31:0] y;
		x = $random(seed);
		y = $random(seed);
		return {x, y[15:0]};
	endfunction
	////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cyc++;
		if (rd === 1'b1 && wait_o === 1'b0)
			chk("readdata", rq.pop_front(), rdata);
		if (done === 1'b1) begin
			le = lq.pop_front();
			if (le[8])
				chk("lookup", {24'h0, le[7:0]}, {24'h0, hit, mask, drop, pen, prio});
			else
				chk("hit", 32'h0, {31'h0, hit});
		end
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 0;
		rdx(14'h1801, 32'h0);
		rdx(14'h1802, 32'h0);
		rdx(14'h1234, 32'h0);
		tmp = $random(seed);
		wrr(14'h1801, tmp);
		rdx(14'h1801, tmp);
		bus(0, 14'h1801, 32'h5a5a5a5a, 4'b0010);
		rdx(14'h1801, {tmp[31:16], 8'h5a, tmp[7:0]});
		wrr(14'h1802, 32'hffffffff);
		rdx(14'h1802, 32'h01ffffff);
		m0 = rmac();
		for (int p = 0; p < 8; p++) begin
			mk(m0, {6'b101000, p[2:0]});
			lk(m0, 2'd1, 3'h7, {2'b11, pm[p], 4'h0});
		end
		mk(m0, {6'b111000, 3'h7});
		lk(m0, 2'd3, 3'h0, {2'b11, 3'h7, 4'h0});
		mk(m0, {6'b101000, 3'h7});
		lk(m0, 2'd3, 3'h0, {2'b11, 3'h0, 4'h0});
		lk(m0, 2'd0, 3'h5, {2'b11, 3'h5, 4'h0});
		m1 = rmac();
		mk(m1, {6'b101100, 3'h7});
		lk(m1, 2'd0, 3'h7, {2'b11, 3'h0, 4'h8});
		m2 = rmac();
		mk(m2, {6'b101010, 3'h1});
		lk(m2, 2'd0, 3'h7, {2'b11, 3'h2, 4'h0});
		wrr(14'h1840, 32'h20);
		lk(m2, 2'd0, 3'h7, {2'b11, 3'h2, 4'h6});
		lrn(m2, 2'd2);
		lk(m2, 2'd0, 3'h7, {2'b11, 3'h2, 4'h6});
		m3 = rmac();
		mk(m3, {6'b110010, 3'h2});
		lk(m3, 2'd0, 3'h7, {2'b11, 3'h4, 4'h0});
		lrn(m3, 2'd1);
		lk(m3, 2'd0, 3'h7, {2'b11, 3'h2, 4'h0});
		repeat (60) @(posedge mclk);
		lk(m3, 2'd0, 3'h7, 9'h000);
		// Relearn the aged-out address into the freed slot
		lrn(m3, 2'd0);
		lk(m3, 2'd0, 3'h7, {2'b11, 3'h1, 4'h0});
		lk(m2, 2'd0, 3'h7, {2'b11, 3'h2, 4'h6});
		mk(m0, 9'h000);
		lk(m0, 2'd0, 3'h7, 9'h000);
		rdx(14'h1808, 32'h0);
		repeat (5) @(posedge mclk);
		summarize();
	end
endmodule
`default_nettype wire
